// *** rtl/ovfs_defs.svh ***
// Purpose: constants of the over-voltage fault status flag block
// Assumes: byte-wide register port, offsets as byte addresses
// Notes:   flags for channels 2..4 sit in bits 1..3
//
// Behaviour
// R1: high-frequency status register at offset 16h, reset value 00h.
// R2: low-frequency status register at offset 18h, reset value 00h.
// R3: high-frequency bits 3,2,1 hold channels 4,3,2.
// R4: high-frequency flag sets when that channel rises above its threshold.
// R5: low-frequency bits 3,2,1 hold channels 4,3,2.
// R6: low-frequency flag sets when that channel rises above its threshold.
// R7: flag reads zero while its interrupt enable is off.
// R8: set flag stays after recovery; only host write-one clears it. The code also clears it when its enable goes off.
// R9: high-frequency write-one clears only while signal is below threshold.
// R10: low-frequency write-one clears only while signal is below threshold.
// R11: bits 7..4 and 0 read zero; writes to them do nothing.
`ifndef OVFS_DEFS_SVH
`define OVFS_DEFS_SVH

// ==========================================================
// register map
`define OVFS_HF_STATUS_ADDR 8'h16
`define OVFS_LF_STATUS_ADDR 8'h18
`define OVFS_STATUS_RESET 8'h00
`define OVFS_FLAG_RESET 3'h0
`define OVFS_UNMAPPED_DATA 8'h00

// ==========================================================
// field layout
`define OVFS_FLAG_LSB 1
`define OVFS_FLAG_MSB 3
`define OVFS_CH2_BIT 1
`define OVFS_CH3_BIT 2
`define OVFS_CH4_BIT 3

`endif

// *** rtl/ovfs_pkg.sv ***
// Purpose: shared types of the over-voltage fault status flag block
// Assumes: three monitored channels, index 0 is channel 2
// Notes:   constants live in ovfs_defs.svh
package ovfs_pkg;

  // ==========================================================
  // types
  typedef logic [2:0] ovfs_ch_t;

  typedef enum logic [1:0]
  {
    OVFS_SEL_NONE,
    OVFS_SEL_HF,
    OVFS_SEL_LF
  } ovfs_sel_e;

endpackage : ovfs_pkg

// *** rtl/ovfs_flag_if.sv ***
// Purpose: bundle between the register front end and one flag bank
// Assumes: one bit per channel, index 0 is channel 2
// Notes:   flags come straight from the bank flops
`timescale 1ns/100ps
interface ovfs_flag_if;
  ovfs_pkg::ovfs_ch_t above;
  ovfs_pkg::ovfs_ch_t enable;
  ovfs_pkg::ovfs_ch_t clr;
  ovfs_pkg::ovfs_ch_t flags;

  modport bank
  (
    input above,
    input enable,
    input clr,
    output flags
  );

  modport ctrl
  (
    output above,
    output enable,
    output clr,
    input flags
  );
endinterface : ovfs_flag_if

// *** rtl/ovfs_flag_bank.sv ***
// Purpose: sticky over-voltage flags of one comparator path
// Assumes: above is high while the signal exceeds its threshold
// Notes:   a disabled channel holds its flag at zero
`timescale 1ns/100ps
`include "ovfs_defs.svh"
module ovfs_flag_bank
(
  input wire logic mclk,   // system clock
  input wire logic rst_n,  // synchronous reset, active low
  ovfs_flag_if.bank fb     // comparator, enable, clear and flags
);

  ovfs_pkg::ovfs_ch_t next_flags;

  // ==========================================================
  // flag update
  always_comb
  begin
    // set while above threshold, clear only when fault has gone
    next_flags = (fb.flags | fb.above) & ~(fb.clr & ~fb.above); // R4 R6 R8 R9 R10
    next_flags = next_flags & fb.enable; // R7
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      fb.flags <= `OVFS_FLAG_RESET;
    else
      fb.flags <= next_flags;
  end

  // ==========================================================
  // checks
  flag_reset_a : assert property (@(posedge mclk) // R1
    !rst_n |=> fb.flags == `OVFS_FLAG_RESET)
    else $error("flags not zero after reset");

  flag_sets_a : assert property (@(posedge mclk) disable iff (!rst_n) // R4
    1'b1 |=> ((fb.flags & $past(fb.above & fb.enable))
      == $past(fb.above & fb.enable)))
    else $error("flag did not set on fault");

  flag_sticky_a : assert property (@(posedge mclk) disable iff (!rst_n) // R8
    1'b1 |=> (($past(fb.flags & ~fb.clr & fb.enable) & ~fb.flags)
      == 3'h0))
    else $error("flag dropped without a clear");

  clear_takes_a : assert property (@(posedge mclk) disable iff (!rst_n) // R9
    1'b1 |=> ((fb.flags & $past(fb.clr & ~fb.above)) == 3'h0))
    else $error("clear of a recovered flag ignored");

  mask_zero_a : assert property (@(posedge mclk) disable iff (!rst_n) // R7
    1'b1 |=> ((fb.flags & ~$past(fb.enable)) == 3'h0))
    else $error("disabled flag reads one");

endmodule : ovfs_flag_bank

// *** rtl/ovfs_status_top.sv ***
// Purpose: over-voltage fault status registers, high and low frequency
// Assumes: byte register port from the serial interface logic
// Notes:   read data valid the cycle after the read strobe
`timescale 1ns/100ps
`include "ovfs_defs.svh"
module ovfs_status_top
(
  input wire logic mclk,                                // system clock
  input wire logic rst_n,                               // sync reset
  input wire logic [7:0] reg_addr,                      // register offset
  input wire logic reg_wr,                              // write strobe
  input wire logic [7:0] reg_wdata,                     // write data
  input wire logic reg_rd,                              // read strobe
  input wire logic [2:0] hf_above,                      // hf over thresh
  input wire logic [2:0] lf_above,                      // lf over thresh
  input wire logic [2:0] hf_overvoltage_irq_enable,     // hf enables
  input wire logic [2:0] lf_overvoltage_irq_enable,     // lf enables
  output logic [7:0] reg_rdata,                         // read data
  output logic reg_rvalid,                              // read data valid
  output logic [2:0] hf_overvoltage_channel_flag,       // hf flags
  output logic [2:0] lf_overvoltage_channel_flag        // lf flags
);

  ovfs_flag_if hf_if ();
  ovfs_flag_if lf_if ();

  ovfs_pkg::ovfs_sel_e sel;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [7:0] hf_overvoltage_fault_status;
  logic [7:0] lf_overvoltage_fault_status;

  // ==========================================================
  // address decode
  always_comb
  begin
    case (reg_addr)
      `OVFS_HF_STATUS_ADDR: sel = ovfs_pkg::OVFS_SEL_HF; // R1
      `OVFS_LF_STATUS_ADDR: sel = ovfs_pkg::OVFS_SEL_LF; // R2
      default: sel = ovfs_pkg::OVFS_SEL_NONE;
    endcase
  end

  // ==========================================================
  // bank hookup
  assign hf_if.above = hf_above;
  assign hf_if.enable = hf_overvoltage_irq_enable;
  assign lf_if.above = lf_above;
  assign lf_if.enable = lf_overvoltage_irq_enable;

  // write-one clear, only flag bits reach the banks
  assign hf_if.clr = (reg_wr && sel == ovfs_pkg::OVFS_SEL_HF) ?
    reg_wdata[`OVFS_FLAG_MSB:`OVFS_FLAG_LSB] : 3'h0; // R9 R11
  assign lf_if.clr = (reg_wr && sel == ovfs_pkg::OVFS_SEL_LF) ?
    reg_wdata[`OVFS_FLAG_MSB:`OVFS_FLAG_LSB] : 3'h0; // R10 R11

  ovfs_flag_bank u_hf_bank
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .fb(hf_if.bank)
  );

  ovfs_flag_bank u_lf_bank
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .fb(lf_if.bank)
  );

  // ==========================================================
  // register images
  always_comb
  begin
    hf_overvoltage_fault_status = `OVFS_STATUS_RESET; // R11
    hf_overvoltage_fault_status[`OVFS_CH4_BIT] = hf_if.flags[2]; // R3
    hf_overvoltage_fault_status[`OVFS_CH3_BIT] = hf_if.flags[1]; // R3
    hf_overvoltage_fault_status[`OVFS_CH2_BIT] = hf_if.flags[0]; // R3
    lf_overvoltage_fault_status = `OVFS_STATUS_RESET; // R11
    lf_overvoltage_fault_status[`OVFS_CH4_BIT] = lf_if.flags[2]; // R5
    lf_overvoltage_fault_status[`OVFS_CH3_BIT] = lf_if.flags[1]; // R5
    lf_overvoltage_fault_status[`OVFS_CH2_BIT] = lf_if.flags[0]; // R5
  end

  // ==========================================================
  // read path
  always_comb
  begin
    next_rvalid = reg_rd;
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (sel)
        ovfs_pkg::OVFS_SEL_HF: next_rdata = hf_overvoltage_fault_status;
        ovfs_pkg::OVFS_SEL_LF: next_rdata = lf_overvoltage_fault_status;
        default: next_rdata = `OVFS_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= `OVFS_STATUS_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  assign hf_overvoltage_channel_flag = hf_if.flags;
  assign lf_overvoltage_channel_flag = lf_if.flags;

  // ==========================================================
  // checks
  hf_read_map_a : assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `OVFS_HF_STATUS_ADDR |=> // R3
      reg_rvalid && reg_rdata[3:1] == $past(hf_if.flags))
    else $error("hf status read mismatch");

  lf_read_map_a : assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `OVFS_LF_STATUS_ADDR |=> // R5
      reg_rvalid && reg_rdata[3:1] == $past(lf_if.flags))
    else $error("lf status read mismatch");

  reserved_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rvalid |-> reg_rdata[7:4] == 4'h0 && !reg_rdata[0]) // R11
    else $error("reserved bits read nonzero");

  hf_reset_read_a : assert property (@(posedge mclk) // R1
    !rst_n ##1 rst_n && reg_rd && reg_addr == `OVFS_HF_STATUS_ADDR
      && hf_above == 3'h0 |=> reg_rdata == `OVFS_STATUS_RESET)
    else $error("hf status not 00h after reset");

  lf_reset_read_a : assert property (@(posedge mclk) // R2
    !rst_n ##1 rst_n && reg_rd && reg_addr == `OVFS_LF_STATUS_ADDR
      && lf_above == 3'h0 |=> reg_rdata == `OVFS_STATUS_RESET)
    else $error("lf status not 00h after reset");

  hf_set_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (hf_above & hf_overvoltage_irq_enable) != 3'h0 |=> // R4
      (hf_overvoltage_channel_flag & $past(hf_above)) != 3'h0)
    else $error("hf fault did not set a flag");

  lf_set_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (lf_above & lf_overvoltage_irq_enable) != 3'h0 |=> // R6
      (lf_overvoltage_channel_flag & $past(lf_above)) != 3'h0)
    else $error("lf fault did not set a flag");

  lf_clear_blocked_a : assert property (@(posedge mclk)
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_LF_STATUS_ADDR
      && (lf_above & lf_overvoltage_irq_enable & reg_wdata[3:1]) != 3'h0
      |=> (lf_overvoltage_channel_flag & $past(lf_above)) != 3'h0) // R10
    else $error("lf clear took while fault present");

  hf_clear_blocked_a : assert property (@(posedge mclk)
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_HF_STATUS_ADDR
      && (hf_above & hf_overvoltage_irq_enable & reg_wdata[3:1]) != 3'h0
      |=> (hf_overvoltage_channel_flag & $past(hf_above)) != 3'h0) // R9
    else $error("hf clear took while fault present");

  flag_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_wr && hf_overvoltage_channel_flag[0]
      && hf_overvoltage_irq_enable[0] ##1 hf_overvoltage_irq_enable[0]
      |-> hf_overvoltage_channel_flag[0]) // R8
    else $error("flag dropped without a write");

  hf_clear_takes_a : assert property (@(posedge mclk) // R9
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_HF_STATUS_ADDR |=>
      (hf_overvoltage_channel_flag & $past(reg_wdata[3:1] & ~hf_above))
      == 3'h0)
    else $error("hf clear of a recovered flag ignored");

  lf_clear_takes_a : assert property (@(posedge mclk) // R10
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_LF_STATUS_ADDR |=>
      (lf_overvoltage_channel_flag & $past(reg_wdata[3:1] & ~lf_above))
      == 3'h0)
    else $error("lf clear of a recovered flag ignored");

  hf_mask_zero_a : assert property (@(posedge mclk) // R7
    disable iff (!rst_n)
    1'b1 |=>
      (hf_overvoltage_channel_flag & ~$past(hf_overvoltage_irq_enable))
      == 3'h0)
    else $error("hf flag set while disabled");

  lf_mask_zero_a : assert property (@(posedge mclk) // R7
    disable iff (!rst_n)
    1'b1 |=>
      (lf_overvoltage_channel_flag & ~$past(lf_overvoltage_irq_enable))
      == 3'h0)
    else $error("lf flag set while disabled");

  hf_spare_write_a : assert property (@(posedge mclk) // R11
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_HF_STATUS_ADDR && reg_wdata[3:1] == 3'h0 |=>
      hf_overvoltage_channel_flag == $past((hf_overvoltage_channel_flag
      | hf_above) & hf_overvoltage_irq_enable))
    else $error("hf spare bit write changed a flag");

  lf_spare_write_a : assert property (@(posedge mclk) // R11
    disable iff (!rst_n)
    reg_wr && reg_addr == `OVFS_LF_STATUS_ADDR && reg_wdata[3:1] == 3'h0 |=>
      lf_overvoltage_channel_flag == $past((lf_overvoltage_channel_flag
      | lf_above) & lf_overvoltage_irq_enable))
    else $error("lf spare bit write changed a flag");

  hf_sticky_a : assert property (@(posedge mclk) // R8
    disable iff (!rst_n)
    !(reg_wr && reg_addr == `OVFS_HF_STATUS_ADDR) |=>
      (hf_overvoltage_channel_flag & $past(hf_overvoltage_channel_flag
      & hf_overvoltage_irq_enable)) == $past(hf_overvoltage_channel_flag
      & hf_overvoltage_irq_enable))
    else $error("hf flag dropped without a clear");

  lf_sticky_a : assert property (@(posedge mclk) // R8
    disable iff (!rst_n)
    !(reg_wr && reg_addr == `OVFS_LF_STATUS_ADDR) |=>
      (lf_overvoltage_channel_flag & $past(lf_overvoltage_channel_flag
      & lf_overvoltage_irq_enable)) == $past(lf_overvoltage_channel_flag
      & lf_overvoltage_irq_enable))
    else $error("lf flag dropped without a clear");

  hf_set_each_a : assert property (@(posedge mclk) // R4
    disable iff (!rst_n)
    1'b1 |=> (hf_overvoltage_channel_flag
      & $past(hf_above & hf_overvoltage_irq_enable))
      == $past(hf_above & hf_overvoltage_irq_enable))
    else $error("hf enabled fault left a flag clear");

  lf_set_each_a : assert property (@(posedge mclk) // R6
    disable iff (!rst_n)
    1'b1 |=> (lf_overvoltage_channel_flag
      & $past(lf_above & lf_overvoltage_irq_enable))
      == $past(lf_above & lf_overvoltage_irq_enable))
    else $error("lf enabled fault left a flag clear");

endmodule : ovfs_status_top

// *** verif/ovfs_host_model.sv ***
// Purpose: host side of the status register port
// Assumes: strobes are one-cycle pulses, driven at the falling edge
// Notes:   released address and data lines show the inverse value
`timescale 1ns/100ps
module ovfs_host_model
(
  input wire logic mclk,          // system clock
  input wire logic reg_rvalid,    // read data valid
  input wire logic [7:0] reg_rdata, // read data
  output logic [7:0] reg_addr,    // register offset
  output logic reg_wr,            // write strobe
  output logic [7:0] reg_wdata,   // write data
  output logic reg_rd             // read strobe
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // ==========================================================
  // bus cycles
  task automatic rd(input logic [7:0] a, output logic [8:0] got);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    got = {reg_rvalid, reg_rdata};
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
endmodule : ovfs_host_model

// *** verif/ovfs_status_top_test.sv ***
// Purpose: self-checking bench of the over-voltage status registers
// Assumes: flags visible one cycle after cause, read data one cycle later
// Notes:   both paths run the same scenarios
`timescale 1ns/100ps
module ovfs_status_top_test;
  logic mclk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [2:0] hf_above, lf_above, hf_en, lf_en;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [2:0] hf_flag, lf_flag;
  logic [8:0] got;
  int failures;
  int n_checks;

  ovfs_status_top i_dut
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .hf_above(hf_above),
    .lf_above(lf_above),
    .hf_overvoltage_irq_enable(hf_en),
    .lf_overvoltage_irq_enable(lf_en),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .hf_overvoltage_channel_flag(hf_flag),
    .lf_overvoltage_channel_flag(lf_flag)
  );

  ovfs_host_model i_host
  (
    .mclk(mclk),
    .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd)
  );

  // ==========================================================
  // helpers
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic drv(input logic lf, input logic [2:0] ab,
                     input logic [2:0] en);
    @(negedge mclk);
    if (lf)
    begin
      lf_above = ab;
      lf_en = en;
    end
    else
    begin
      hf_above = ab;
      hf_en = en;
    end
  endtask : drv

  task automatic results();
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // ==========================================================
  // scenarios
  task automatic reset_test();
    i_host.rd(8'h16, got);
    check(got, 9'h100);
    i_host.rd(8'h18, got);
    check(got, 9'h100);
    i_host.rd(8'h17, got);
    check(got, 9'h100);
  endtask : reset_test

  task automatic path_test(input logic lf);
    logic [7:0] a;
    a = lf ? 8'h18 : 8'h16;
    for (int i = 0; i < 3; i++)
    begin
      drv(lf, 3'h1 << i, 3'h7);
      drv(lf, 3'h0, 3'h7);
      check({6'h0, lf ? lf_flag : hf_flag}, {6'h0, 3'h1 << i});
      i_host.wr(a, 8'hf1);
      i_host.rd(a, got);
      check(got, {5'h10, 3'h1 << i, 1'b0});
      i_host.wr(a, 8'h0e);
      i_host.rd(a, got);
      check(got, 9'h100);
    end
    drv(lf, 3'h7, 3'h7);
    i_host.wr(a, 8'hff);
    drv(lf, 3'h0, 3'h7);
    i_host.rd(a, got);
    check(got, 9'h10e);
    i_host.wr(a, 8'hff);
    i_host.rd(a, got);
    check(got, 9'h100);
    drv(lf, 3'h7, 3'h0);
    drv(lf, 3'h7, 3'h0);
    check({6'h0, lf ? lf_flag : hf_flag}, 9'h000);
    i_host.rd(a, got);
    check(got, 9'h100);
    drv(lf, 3'h0, 3'h7);
  endtask : path_test

  task automatic reset_again_test();
    drv(1'b0, 3'h7, 3'h7);
    drv(1'b1, 3'h7, 3'h7);
    drv(1'b0, 3'h0, 3'h7);
    drv(1'b1, 3'h0, 3'h7);
    check({6'h0, hf_flag}, 9'h007);
    check({6'h0, lf_flag}, 9'h007);
    rst_n = 1'b0;
    repeat (7) @(negedge mclk);
    fork
      begin
        @(negedge mclk);
        rst_n = 1'b1;
      end
      i_host.rd(8'h18, got);
    join
    check(got, 9'h100);
    i_host.rd(8'h16, got);
    check(got, 9'h100);
  endtask : reset_again_test

  // ==========================================================
  // clock, reset, sequence, watchdog
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    rst_n = 1'b0;
    hf_above = 3'h0;
    lf_above = 3'h0;
    hf_en = 3'h7;
    lf_en = 3'h7;
    failures = 0;
    n_checks = 0;
    repeat (7) @(negedge mclk);
    // first read rides on the first edge out of reset
    fork
      begin
        @(negedge mclk);
        rst_n = 1'b1;
      end
      reset_test();
    join
    path_test(1'b0);
    path_test(1'b1);
    reset_again_test();
    results();
  end

  initial
  begin
    repeat (2000) @(posedge mclk);
    failures++;
    results();
  end
endmodule : ovfs_status_top_test
